/* rtl/sfp_pkg.sv */
// Constants, register map and types of the switch forwarding-policy block
package sfp_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int NPORT = 3;
  localparam int VLAN_ENTRIES = 16;
  localparam int VID_W = 12;
  localparam int FID_W = 4;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [6:0] REG_GLOBAL = 7'h05;
  localparam logic [6:0] REG_SPECIAL = 7'h0B;
  localparam logic [6:0] REG_PORT_BASE = 7'h10;
  localparam logic [6:0] REG_PORT_STRIDE = 7'h10;
  localparam logic [6:0] OFS_SNIFF = 7'h01;
  localparam logic [6:0] OFS_VLANCTL = 7'h02;
  localparam logic [6:0] OFS_TAG_HI = 7'h03;
  localparam logic [6:0] OFS_TAG_LO = 7'h04;
  localparam logic [6:0] REG_VT_INDEX = 7'h70;
  localparam logic [6:0] REG_VT_VID_LO = 7'h71;
  localparam logic [6:0] REG_VT_VID_HI = 7'h72;
  localparam logic [6:0] REG_VT_COMMIT = 7'h73;
  localparam logic [6:0] REG_OPTIONS = 7'h74;
  localparam logic [6:0] REG_STATUS = 7'h75;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int BIT_MIRROR_AND = 0;
  localparam int SCHEME_LSB = 2;
  localparam int BIT_IGMP_EN = 6;
  localparam int BIT_SPECIAL_EN = 0;
  localparam int BIT_SPLIT = 0;
  localparam int BIT_TAG_INSERT = 2;
  localparam int BIT_PORT_PRIO = 4;
  localparam int BIT_TX_SNIFF = 5;
  localparam int BIT_RX_SNIFF = 6;
  localparam int BIT_SNIFFER = 7;
  localparam int BIT_LEARN_DIS = 0;
  localparam int BIT_RX_EN = 1;
  localparam int BIT_TX_EN = 2;
  localparam int BIT_DISCARD_NONPVID = 5;
  localparam int BIT_INGRESS_FILTER = 6;
  localparam int BIT_SNIFF_BAD = 0;
  localparam int BIT_VLAN_MODE = 1;
  localparam int BIT_VT_VALID = 3;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] VLANCTL_RESET = 8'h06;

  // ************************************************************
  // Tag and frame constants
  // ************************************************************
  localparam logic [11:0] SPECIAL_TAG_ID = 12'h810;
  localparam logic [15:0] TPID_8021Q = 16'h8100;
  localparam logic [3:0] IP_VERSION_V4 = 4'h4;
  localparam logic [7:0] IP_PROTO_IGMP = 8'h02;
  localparam logic [3:0] MASK_PORT1 = 4'h1;
  localparam logic [3:0] MASK_PORT2 = 4'h2;
  localparam logic [1:0] PORT_CPU = 2'h2;
  localparam logic [3:0] RATIO_10 = 4'hA;
  localparam logic [3:0] RATIO_5 = 4'h5;
  localparam logic [3:0] RATIO_2 = 4'h2;

  // Scheduling schemes in field order, zero to three
  typedef enum logic [1:0] {
    SFP_STRICT,
    SFP_RATIO_10,
    SFP_RATIO_5,
    SFP_RATIO_2
  } sfp_scheme_t;

endpackage : sfp_pkg

/* rtl/sfp_forwarding_policy.sv */
// Forwarding decision, mirroring, special tagging and queue scheduling of a 3-port switch
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
module sfp_forwarding_policy (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [6:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic [2:0] i_strap_split_queue_enable,
  input wire logic i_strap_scheme_select_high,
  input wire logic i_strap_scheme_select_low,
  input wire logic [2:0] i_strap_port_priority_enable,
  input wire logic i_frm_valid,
  input wire logic [1:0] i_frm_port,
  input wire logic i_frm_tagged,
  input wire logic [15:0] i_frm_tci,
  input wire logic [3:0] i_frm_special_mask,
  input wire logic i_frm_rx_error,
  input wire logic i_frm_is_ip,
  input wire logic [3:0] i_frm_ip_version,
  input wire logic [7:0] i_frm_ip_protocol,
  input wire logic i_frm_high_class,
  input wire logic i_static_hit,
  input wire logic i_static_use_fid,
  input wire logic [3:0] i_static_fid,
  input wire logic [2:0] i_static_ports,
  input wire logic i_dyn_da_hit,
  input wire logic [1:0] i_dyn_da_port,
  input wire logic i_dyn_sa_hit,
  output logic o_dec_valid,
  output logic [2:0] o_dec_dest,
  output logic [3:0] o_dec_fid,
  output logic o_dec_discard,
  output logic o_dec_learn,
  output logic o_dec_refresh,
  output logic o_dec_mirrored,
  output logic [2:0] o_dec_high_queue,
  output logic o_tag_insert,
  output logic o_tag_rewrite,
  output logic [15:0] o_tag_word,
  output logic [15:0] o_tag_tci,
  output logic o_crc_recalc,
  input wire logic [2:0] i_q_high_busy,
  input wire logic [2:0] i_q_low_busy,
  input wire logic [2:0] i_tx_take,
  output logic [2:0] o_tx_pick_high
);

  // ************************************************************
  // Functions
  // ************************************************************
  // One-hot port from a port number; number 3 maps to nothing
  function automatic logic [2:0] port_onehot(input logic [1:0] num);
    logic [2:0] r;
    r = 3'h0;
    if (num < 2'h3) begin
      r[num] = 1'b1;
    end
    return r;
  endfunction : port_onehot

  function automatic logic [3:0] ratio_of(input sfp_pkg::sfp_scheme_t s);
    logic [3:0] r;
    r = sfp_pkg::RATIO_2;
    case (s)
      sfp_pkg::SFP_RATIO_10: r = sfp_pkg::RATIO_10;
      sfp_pkg::SFP_RATIO_5: r = sfp_pkg::RATIO_5;
      default: r = sfp_pkg::RATIO_2;
    endcase
    return r;
  endfunction : ratio_of

  // ************************************************************
  // Register file
  // ************************************************************
  logic [7:0] regs [0:127];
  logic [11:0] vt_vid [0:sfp_pkg::VLAN_ENTRIES-1];
  logic [3:0] vt_fid [0:sfp_pkg::VLAN_ENTRIES-1];
  logic [2:0] vt_members [0:sfp_pkg::VLAN_ENTRIES-1];
  logic [sfp_pkg::VLAN_ENTRIES-1:0] vt_valid;
  logic [7:0] status;
  wire vt_commit = i_wr && (i_addr == sfp_pkg::REG_VT_COMMIT);
  wire [3:0] vt_index = regs[sfp_pkg::REG_VT_INDEX][3:0];
  wire [7:0] rd_word = (i_addr == sfp_pkg::REG_STATUS) ? status : regs[i_addr];

  // Byte registers; reset leaves the ports enabled for receive and transmit
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int a = 0; a < 128; a++) begin
        regs[a] <= ((a[3:0] == 4'h2) && (a >= 16) && (a < 64)) ?
                   sfp_pkg::VLANCTL_RESET : sfp_pkg::REG_RESET;
      end
    end else if (i_wr) begin
      regs[i_addr] <= i_wdata;
    end
  end

  // VLAN table entry is written whole on the commit byte
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      vt_valid <= '0;
      for (int e = 0; e < sfp_pkg::VLAN_ENTRIES; e++) begin
        vt_vid[e] <= 12'h000;
        vt_fid[e] <= 4'h0;
        vt_members[e] <= 3'h0;
      end
    end else if (vt_commit) begin
      vt_vid[vt_index] <= {regs[sfp_pkg::REG_VT_VID_HI][3:0], regs[sfp_pkg::REG_VT_VID_LO]};
      vt_fid[vt_index] <= regs[sfp_pkg::REG_VT_VID_HI][7:4];
      vt_members[vt_index] <= i_wdata[2:0];
      vt_valid[vt_index] <= i_wdata[sfp_pkg::BIT_VT_VALID];
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= i_rd ? rd_word : 8'h00;
    end
  end

  // ************************************************************
  // Strap synchronisers
  // ************************************************************
  logic [7:0] strap_meta;
  logic [7:0] strap_sync;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      strap_meta <= 8'h00;
      strap_sync <= 8'h00;
    end else begin
      strap_meta <= {i_strap_scheme_select_high, i_strap_scheme_select_low,
                     i_strap_port_priority_enable, i_strap_split_queue_enable};
      strap_sync <= strap_meta;
    end
  end

  // ************************************************************
  // Field decode
  // ************************************************************
  wire [7:0] glob = regs[sfp_pkg::REG_GLOBAL];
  wire [7:0] opts = regs[sfp_pkg::REG_OPTIONS];
  wire mirror_and = glob[sfp_pkg::BIT_MIRROR_AND];
  wire igmp_en = glob[sfp_pkg::BIT_IGMP_EN];
  wire vlan_mode = opts[sfp_pkg::BIT_VLAN_MODE];
  wire sniff_bad = opts[sfp_pkg::BIT_SNIFF_BAD];
  // Straps OR into the field so either may pick the scheme
  wire [1:0] scheme_code = glob[sfp_pkg::SCHEME_LSB +: 2] | strap_sync[7:6];
  wire [2:0] split_q;
  wire [2:0] port_prio;
  wire [2:0] rx_sniff;
  wire [2:0] tx_sniff;
  wire [2:0] sniffer;
  wire [2:0] rx_en;
  wire [2:0] tx_en;
  wire [2:0] learn_dis;
  wire [2:0] in_filter;
  wire [2:0] drop_nonpvid;
  wire [15:0] def_tag [0:2];

  // Per-port fields from each port's register group
  for (genvar p = 0; p < sfp_pkg::NPORT; p++) begin : g_port
    localparam logic [6:0] BASE = 7'(sfp_pkg::REG_PORT_BASE + p * sfp_pkg::REG_PORT_STRIDE);
    wire [7:0] ctl = regs[BASE];
    wire [7:0] snf = regs[BASE + sfp_pkg::OFS_SNIFF];
    wire [7:0] vct = regs[BASE + sfp_pkg::OFS_VLANCTL];
    assign split_q[p] = ctl[sfp_pkg::BIT_SPLIT] | strap_sync[p];
    assign port_prio[p] = ctl[sfp_pkg::BIT_PORT_PRIO] | strap_sync[p+3];
    assign rx_sniff[p] = snf[sfp_pkg::BIT_RX_SNIFF];
    assign tx_sniff[p] = snf[sfp_pkg::BIT_TX_SNIFF];
    assign sniffer[p] = snf[sfp_pkg::BIT_SNIFFER];
    assign rx_en[p] = vct[sfp_pkg::BIT_RX_EN];
    assign tx_en[p] = vct[sfp_pkg::BIT_TX_EN];
    assign learn_dis[p] = vct[sfp_pkg::BIT_LEARN_DIS];
    assign in_filter[p] = vct[sfp_pkg::BIT_INGRESS_FILTER];
    assign drop_nonpvid[p] = vct[sfp_pkg::BIT_DISCARD_NONPVID];
    assign def_tag[p] = {regs[BASE + sfp_pkg::OFS_TAG_HI], regs[BASE + sfp_pkg::OFS_TAG_LO]};
  end

  // Special tagging needs both the global bit and the processor port insert bit
  wire special_on = regs[sfp_pkg::REG_SPECIAL][sfp_pkg::BIT_SPECIAL_EN] &&
                    regs[sfp_pkg::REG_PORT_BASE + 7'(2) * sfp_pkg::REG_PORT_STRIDE]
                        [sfp_pkg::BIT_TAG_INSERT];

  // ************************************************************
  // VLAN lookup
  // ************************************************************
  wire [2:0] in_oh = port_onehot(i_frm_port);
  wire [1:0] in_idx = (i_frm_port == 2'h3) ? sfp_pkg::PORT_CPU : i_frm_port;
  wire [15:0] in_tag = def_tag[in_idx];
  wire [11:0] port_default_vlan_id = in_tag[11:0];
  wire [11:0] frm_vid = i_frm_tci[11:0];
  wire vid_null = (frm_vid == 12'h000);
  wire [11:0] eff_vid = (i_frm_tagged && !vid_null) ? frm_vid : port_default_vlan_id;
  wire [sfp_pkg::VLAN_ENTRIES-1:0] vt_match;
  for (genvar e = 0; e < sfp_pkg::VLAN_ENTRIES; e++) begin : g_vt
    assign vt_match[e] = vt_valid[e] && (vt_vid[e] == eff_vid);
  end

  // Lowest matching entry wins if software loads duplicates
  logic [3:0] vt_fid_sel;
  logic [2:0] vt_mem_sel;
  always_comb begin
    vt_fid_sel = 4'h0;
    vt_mem_sel = 3'h0;
    for (int e = sfp_pkg::VLAN_ENTRIES - 1; e >= 0; e--) begin
      if (vt_match[e]) begin
        vt_fid_sel = vt_fid[e];
        vt_mem_sel = vt_members[e];
      end
    end
  end
  wire vt_hit = |vt_match;

  // ************************************************************
  // Forwarding decision
  // ************************************************************
  wire from_cpu = (in_idx == sfp_pkg::PORT_CPU);
  // Masks are parsed only on the processor port
  wire override = special_on && from_cpu && (i_frm_special_mask != 4'h0);
  wire igmp_trap = igmp_en && i_frm_is_ip && (i_frm_ip_version == sfp_pkg::IP_VERSION_V4) &&
                   (i_frm_ip_protocol == sfp_pkg::IP_PROTO_IGMP);
  wire vid_bad = vlan_mode && !vt_hit;
  wire filt_bad = vlan_mode && in_filter[in_idx] && !(|(vt_mem_sel & in_oh));
  wire port_default_vlan_id_bad = drop_nonpvid[in_idx] && i_frm_tagged && !vid_null && (frm_vid != port_default_vlan_id);
  wire policy_drop = !override && (vid_bad || filt_bad || port_default_vlan_id_bad);
  wire static_ok = i_static_hit && (!vlan_mode || !i_static_use_fid ||
                   (i_static_fid == vt_fid_sel));
  wire [2:0] flood = vlan_mode ? vt_mem_sel : 3'h7;
  wire [2:0] lookup_ports = static_ok ? i_static_ports :
                            i_dyn_da_hit ? port_onehot(i_dyn_da_port) : flood;
  // A blocked ingress still reaches the processor, a blocked egress still hears it
  wire [2:0] state_mask = rx_en[in_idx] ? (tx_en | 3'h4 | (from_cpu ? 3'h7 : 3'h0)) : 3'h4;
  wire [2:0] normal_dest = igmp_trap ? 3'h4 : (lookup_ports & ~in_oh & state_mask);
  wire [2:0] base_dest = override ? i_frm_special_mask[2:0] :
                         (policy_drop || i_frm_rx_error) ? 3'h0 : normal_dest;
  // Mirror conditions; errored frames only by option
  wire rx_mirror = rx_sniff[in_idx] && (!i_frm_rx_error || sniff_bad);
  wire tx_mirror = |(base_dest & tx_sniff);
  wire mirror_hit = !policy_drop && (mirror_and ? (rx_mirror && tx_mirror)
                                                : (rx_mirror || tx_mirror));
  // OR keeps the normal copy intact and adds the sniffer once
  wire [2:0] final_dest = base_dest | (mirror_hit ? sniffer : 3'h0);
  wire learn_ok = !policy_drop && !i_frm_rx_error && !learn_dis[in_idx] && !override;
  wire is_high = port_prio[in_idx] || i_frm_high_class;
  wire [2:0] high_q = (is_high ? 3'h7 : 3'h0) & split_q;

  // ************************************************************
  // Upstream special tag to the processor
  // ************************************************************
  wire up_tag = special_on && !from_cpu && final_dest[2];
  wire [3:0] src_mask = (i_frm_port == 2'h0) ? sfp_pkg::MASK_PORT1 : sfp_pkg::MASK_PORT2;
  wire [15:0] null_fix_tci = {i_frm_tci[15:12], vid_null ? port_default_vlan_id : frm_vid};
  wire [15:0] up_tci = i_frm_tagged ? null_fix_tci : in_tag;
  wire [15:0] up_word = {sfp_pkg::SPECIAL_TAG_ID, src_mask};

  // Decision outputs, one cycle after the descriptor
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_dec_valid <= 1'b0;
      o_dec_dest <= 3'h0;
      o_dec_fid <= 4'h0;
      o_dec_discard <= 1'b0;
      o_dec_learn <= 1'b0;
      o_dec_refresh <= 1'b0;
      o_dec_mirrored <= 1'b0;
      o_dec_high_queue <= 3'h0;
    end else begin
      o_dec_valid <= i_frm_valid;
      o_dec_dest <= i_frm_valid ? final_dest : 3'h0;
      o_dec_fid <= vt_fid_sel;
      o_dec_discard <= i_frm_valid && (final_dest == 3'h0);
      o_dec_learn <= i_frm_valid && learn_ok && !i_dyn_sa_hit;
      o_dec_refresh <= i_frm_valid && learn_ok && i_dyn_sa_hit;
      o_dec_mirrored <= i_frm_valid && mirror_hit;
      o_dec_high_queue <= i_frm_valid ? high_q : 3'h0;
    end
  end

  // Tag editing for the processor copy; other egress copies stay as they are
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_tag_insert <= 1'b0;
      o_tag_rewrite <= 1'b0;
      o_tag_word <= sfp_pkg::TPID_8021Q;
      o_tag_tci <= 16'h0000;
      o_crc_recalc <= 1'b0;
    end else begin
      o_tag_insert <= i_frm_valid && up_tag && !i_frm_tagged;
      o_tag_rewrite <= i_frm_valid && up_tag && i_frm_tagged;
      o_tag_word <= up_tag ? up_word : sfp_pkg::TPID_8021Q;
      o_tag_tci <= up_tci;
      o_crc_recalc <= i_frm_valid && up_tag;
    end
  end

  // Status byte shows the last decision
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      status <= 8'h00;
    end else if (i_frm_valid) begin
      status <= {override, igmp_trap, mirror_hit, policy_drop, vt_hit, final_dest};
    end
  end

  // ************************************************************
  // Transmit queue scheduling
  // ************************************************************
  wire [3:0] ratio = ratio_of(sfp_pkg::sfp_scheme_t'(scheme_code));
  wire strict = (scheme_code == 2'(sfp_pkg::SFP_STRICT));
  logic [3:0] high_run [0:2];
  for (genvar q = 0; q < sfp_pkg::NPORT; q++) begin : g_sched
    wire both = i_q_high_busy[q] && i_q_low_busy[q];
    // One low after ratio highs while both wait; strict waits for an empty high queue
    wire want_high = split_q[q] && i_q_high_busy[q] &&
                     (!i_q_low_busy[q] || strict || (high_run[q] < ratio));
    always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        high_run[q] <= 4'h0;
      end else if (i_tx_take[q]) begin
        high_run[q] <= (o_tx_pick_high[q] && both) ? high_run[q] + 4'h1 : 4'h0;
      end
    end
    always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        o_tx_pick_high[q] <= 1'b0;
      end else begin
        o_tx_pick_high[q] <= want_high;
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_override;
    i_frm_valid && override;
  endsequence
  sequence s_up_untagged;
    i_frm_valid && up_tag && !i_frm_tagged;
  endsequence

  override_dest_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    s_override |=> (o_dec_dest & $past(i_frm_special_mask[2:0])) == $past(i_frm_special_mask[2:0]))
    else $error("override mask not forwarded");
  special_gate_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_crc_recalc |-> $past(special_on) && $past(final_dest[2]))
    else $error("special tag without both enables");
  mask_upstream_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (o_tag_insert || o_tag_rewrite) |-> (o_tag_word == 16'h8101 || o_tag_word == 16'h8102))
    else $error("bad upstream port mask");
  insert_tci_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    s_up_untagged |=> o_tag_insert && o_tag_tci == $past(in_tag))
    else $error("inserted tci not port vid");
  igmp_only_cpu_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_frm_valid && igmp_trap && !override && !mirror_hit && !policy_drop && !i_frm_rx_error)
      |=> o_dec_dest == 3'h4)
    else $error("igmp frame not trapped");
  unknown_vid_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_frm_valid && vid_bad && !override) |=> !o_dec_learn && !o_dec_refresh &&
      o_dec_dest == 3'h0)
    else $error("unknown vid not dropped");
  mirror_and_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_dec_mirrored && $past(mirror_and) |-> $past(rx_mirror) && $past(tx_mirror))
    else $error("and-mirror without both sides");
  sniff_once_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_dec_mirrored |-> ((o_dec_dest & $past(sniffer)) == $past(sniffer)) &&
      ((o_dec_dest & $past(base_dest)) == $past(base_dest)))
    else $error("mirror copy lost or normal copy altered");
  unsplit_low_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !split_q[0] ##1 !split_q[0] |-> !o_tx_pick_high[0] && !o_dec_high_queue[0])
    else $error("unsplit queue used high side");
  strict_high_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (strict && split_q[2] && i_q_high_busy[2]) |=> o_tx_pick_high[2])
    else $error("strict scheme skipped high queue");

endmodule : sfp_forwarding_policy

/* dv/sfp_tx_model.sv */
// Transmitter model that drains the processor port queues
`timescale 1ns/1ns
module sfp_tx_model (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_run,
  input wire logic [2:0] i_pick_high,
  output logic [2:0] o_high_busy,
  output logic [2:0] o_low_busy,
  output logic [2:0] o_take,
  output logic [8:0] o_seq,
  output logic o_done
);
  logic [3:0] hi;
  logic [3:0] lo;
  logic [1:0] gap;
  // Only the processor port holds frames
  assign o_high_busy = {hi != 4'h0, 2'b00};
  assign o_low_busy = {lo != 4'h0, 2'b00};
  assign o_done = (hi == 4'h0) && (lo == 4'h0);
  // A take every third cycle, so the pick has settled after each take
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      hi <= 4'h6;
      lo <= 4'h3;
      gap <= 2'h0;
      o_take <= 3'h0;
      o_seq <= 9'h000;
    end else if (i_run && !o_done && gap == 2'h2) begin
      o_take <= 3'h4;
      o_seq <= {o_seq[7:0], i_pick_high[2]};
      hi <= i_pick_high[2] ? hi - 4'h1 : hi;
      lo <= i_pick_high[2] ? lo : lo - 4'h1;
      gap <= 2'h0;
    end else begin
      o_take <= 3'h0;
      gap <= i_run ? gap + 2'h1 : 2'h0;
    end
  end
endmodule : sfp_tx_model

/* dv/tb_switch_forwarding_policy.sv */
// Self-checking bench of the switch forwarding-policy block
`timescale 1ns/1ns
module tb_switch_forwarding_policy;
  logic i_clk, i_resetn, i_wr, i_rd, vld, ip, run, done, mir, ins, crc, dv, dsc, lrn, rwr;
  logic [6:0] i_addr;
  logic [7:0] i_wdata, o_rdata;
  logic [1:0] prt;
  logic [3:0] msk, fid;
  logic [15:0] aux, word, tci;
  logic [2:0] sp, dst, hb, lb, tk, pk, hq;
  logic [8:0] seq;
  logic [7:0] proto;
  int fail_count, cmp_count;
  sfp_forwarding_policy DUT (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_strap_split_queue_enable(3'h0), .i_strap_scheme_select_high(1'b0),
    .i_strap_scheme_select_low(1'b0), .i_strap_port_priority_enable(3'h0),
    .i_frm_valid(vld), .i_frm_port(prt), .i_frm_tagged(aux[0]), .i_frm_tci(aux),
    .i_frm_special_mask(msk), .i_frm_rx_error(aux[1]), .i_frm_is_ip(ip),
    .i_frm_ip_version(4'h4), .i_frm_ip_protocol(proto), .i_frm_high_class(aux[2]),
    .i_static_hit(|sp), .i_static_use_fid(aux[3]), .i_static_fid(aux[7:4]),
    .i_static_ports(sp), .i_dyn_da_hit(aux[8]), .i_dyn_da_port(aux[10:9]),
    .i_dyn_sa_hit(aux[11]), .o_dec_valid(dv), .o_dec_dest(dst), .o_dec_fid(fid),
    .o_dec_discard(dsc), .o_dec_learn(lrn), .o_dec_refresh(), .o_dec_mirrored(mir),
    .o_dec_high_queue(hq), .o_tag_insert(ins), .o_tag_rewrite(rwr), .o_tag_word(word),
    .o_tag_tci(tci), .o_crc_recalc(crc), .i_q_high_busy(hb), .i_q_low_busy(lb),
    .i_tx_take(tk), .o_tx_pick_high(pk));
  sfp_tx_model PEER (.i_clk(i_clk), .i_resetn(i_resetn), .i_run(run), .i_pick_high(pk),
    .o_high_busy(hb), .o_low_busy(lb), .o_take(tk), .o_seq(seq), .o_done(done));
  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  // Result is settled 1 ns after the answer edge
  task automatic rd(input logic [6:0] a);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
  endtask : rd
  task automatic frm(input logic [1:0] p, input logic [3:0] m, input logic i, input logic [2:0] s);
    @(posedge i_clk);
    prt <= p;
    msk <= m;
    ip <= i;
    sp <= s;
    vld <= 1'b1;
    @(posedge i_clk);
    vld <= 1'b0;
    #1;
  endtask : frm
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report
  task automatic t_tag;
    wr(7'h0B, 8'h01);
    frm(2'h0, 4'h0, 1'b0, 3'h4);
    chk(word, 16'h8100);
    wr(7'h30, 8'h04);
    rd(7'h30);
    chk(16'(o_rdata), 16'h0004);
    frm(2'h0, 4'h0, 1'b0, 3'h4);
    chk({word[15:1], ins & crc}, 16'h8101);
    chk(16'({dv, dst, dsc, lrn}), 16'h0031);
    aux <= 16'h5001;
    frm(2'h0, 4'h0, 1'b0, 3'h4);
    chk(tci, 16'h5001);
    chk(16'({ins, rwr}), 16'h0001);
    aux <= 16'h0000;
    frm(2'h1, 4'h0, 1'b0, 3'h4);
    chk(word, 16'h8102);
    frm(2'h0, 4'h0, 1'b0, 3'h2);
    chk(16'({dst, ins}), 16'h0004);
    $display("tagging done");
  endtask : t_tag
  task automatic t_steer;
    wr(7'h12, 8'h00);
    frm(2'h2, 4'h1, 1'b0, 3'h2);
    chk(16'(dst), 16'h0001);
    wr(7'h12, 8'h06);
    wr(7'h05, 8'h40);
    proto <= 8'h02;
    frm(2'h0, 4'h0, 1'b1, 3'h2);
    chk(16'(dst), 16'h0004);
    proto <= 8'h11;
    frm(2'h0, 4'h0, 1'b1, 3'h2);
    chk(16'(dst), 16'h0002);
    wr(7'h05, 8'h00);
    wr(7'h74, 8'h02);
    frm(2'h0, 4'h0, 1'b0, 3'h2);
    chk(16'({dst, dsc, lrn}), 16'h0002);
    wr(7'h72, 8'h30);
    wr(7'h73, 8'h0F);
    frm(2'h0, 4'h0, 1'b0, 3'h0);
    chk(16'({fid, dst, lrn}), 16'h003D);
    wr(7'h74, 8'h00);
    wr(7'h11, 8'h40);
    wr(7'h21, 8'h80);
    frm(2'h0, 4'h0, 1'b0, 3'h4);
    chk(16'({dst, mir}), 16'h000D);
    frm(2'h0, 4'h0, 1'b0, 3'h2);
    chk(16'(dst), 16'h0002);
    wr(7'h05, 8'h01);
    frm(2'h0, 4'h0, 1'b0, 3'h4);
    chk(16'({dst, mir}), 16'h0008);
    $display("steering done");
  endtask : t_steer
  // Split processor queue, 2:1 scheme, both queues busy
  task automatic t_sched;
    wr(7'h30, 8'h05);
    wr(7'h05, 8'h0C);
    run <= 1'b1;
    for (int i = 0; i < 200 && done !== 1'b1; i++) @(posedge i_clk);
    if (done !== 1'b1) begin
      fail_count++;
      final_report();
    end
    chk(16'(seq), 16'h01B6);
    wr(7'h10, 8'h10);
    frm(2'h0, 4'h0, 1'b0, 3'h4);
    chk(16'(hq), 16'h0004);
    $display("scheduling done");
  endtask : t_sched
  initial begin
    forever #10 i_clk = ~i_clk;
  end
  initial begin
    {i_clk, i_resetn, i_wr, i_rd, vld, ip, run, i_addr, i_wdata, prt, msk, sp, aux, proto} = '0;
    repeat (8) @(posedge i_clk);
    i_resetn <= 1'b1;
    t_tag();
    t_steer();
    t_sched();
    final_report();
  end
endmodule : tb_switch_forwarding_policy
